/* design/rolling_code_config_store.sv */
// Configuration store with APB access, serial loader and option-driven key and pin logic
//
// How it works
// - With resync option on, a key held over 10 s pulses a sync request.
// - Option byte bit 6 routes the indicator to radio or clock-out pin.
// - Option byte bit 5 picks the 3V or 6V comparator range.
// - With cutoff option on, a key held over 80 s stops transmission.
// - Two gap bits give 0, 20, 50 or 100 ms between frames.
// - Factory lock bit refuses every write to the reserved byte.
// - Array lock bit refuses writes to the whole configuration array.
// - Layout bits switch preamble, sync, key identity and parity fields.
// - Layout bit 6 sends sync in configured coding or plain NRZ.
// - Key identity field length is 0, 20 or 24 bits.
// - Rolling code field length is 24 or 36 bits.
// - Layout bit 0 turns the low battery detection on or off.
// - Family bit and three format bits pick one of sixteen codings.
// - Polarity bit sets transmit idle level and data polarity.
// - Time base bit picks infrared or radio tick for bit timing.
// - Six-bit gap divider spans coding and prescaler bytes.
// - Radio and infrared six-bit dividers come from bytes three and four.
// - Bytes five to seven give the rolling code seed.
// - Bytes eight to ten give the key identity value.
// - Byte eleven gives the sync pattern.
// - Serial load takes option byte bit 7 as its first bit.
// - Both lock bits set and supply lost disables the chip for good.
// - Comparator threshold near 4.4-4.8V for 6V, 2.2-2.4V for 3V.
`timescale 1ns/100ps
`include "rolling_code_config_map.svh"

module rolling_code_config_store #(
    parameter int MS_CYCLES = `CLK_PER_MS,
    parameter int RESYNC_MS = `RESYNC_HOLD_MS,
    parameter int CUTOFF_MS = `CUTOFF_HOLD_MS,
    parameter int ADDR_W    = 8
) (
    input  wire logic                         clk,
    input  wire logic                         rst,

    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,

    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,

    input  wire logic                         load_start,
    input  wire logic                         load_bit,
    input  wire logic                         load_bit_valid,
    output logic                              load_done,

    input  wire logic                         supply_lost,
    input  wire logic                         key_down,
    input  wire logic                         led_on,
    input  wire logic                         tx_active,
    input  wire logic                         tx_data,

    input  wire logic                         radio_tick,
    input  wire logic                         infrared_tick,
    input  wire logic                         cell_below_3v_range,
    input  wire logic                         cell_below_6v_range,

    output rolling_code_config_pkg::cfg_s     settings,
    output logic                              resync_request,
    output logic                              tx_cutoff,
    output logic                              low_cell,
    output logic                              tx_pin,
    output logic                              bit_tick,
    output logic                              radio_enable_indicator_pin,
    output logic                              clock_out_indicator_pin,
    output logic                              chip_disabled
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] merge_lane(input logic [7:0] old_b, input logic [7:0] new_b,
                                              input logic en);
        merge_lane = en ? new_b : old_b;
    endfunction : merge_lane

    function automatic logic [6:0] gap_ms(input logic [1:0] sel);
        unique case (sel)
            2'b00: gap_ms = `GAP_MS_0;
            2'b01: gap_ms = `GAP_MS_1;
            2'b10: gap_ms = `GAP_MS_2;
            2'b11: gap_ms = `GAP_MS_3;
        endcase
    endfunction : gap_ms

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [7:0]            cfg_mem [`CFG_BYTES];

    logic [`CFG_BITS-1:0]  shift_reg;
    logic [6:0]            shift_count;
    logic                  loading;

    logic                  refused;

    logic [15:0]           ms_count;
    logic [`HOLD_W-1:0]    hold_ms;
    logic                  resync_sent;

    ////////////////////////////////////////////////////////////////////////
    // Decoding

    wire [3:0]  index        = paddr[5:2];
    wire        addr_ok      = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:6] == '0);
    wire        setup        = psel && !penable;
    wire        access       = psel && penable;

    wire        idx_byte     = (index <= `IDX_INFRARED_PRESC);
    wire        idx_seed     = (index == `IDX_ROLLING_SEED);
    wire        idx_key      = (index == `IDX_KEY_IDENTITY);
    wire        idx_sync     = (index == `IDX_SYNC_PATTERN);
    wire        idx_factory  = (index == `IDX_FACTORY_RESERVED);
    wire        idx_status   = (index == `IDX_STATUS);

    wire        mapped       = addr_ok && (idx_byte || idx_seed || idx_key || idx_sync ||
                                           idx_factory || idx_status);

    wire        array_lock   = cfg_mem[0][`B0_ARRAY_LOCK];
    wire        factory_lock = cfg_mem[0][`B0_FACTORY_LOCK];
    wire        array_hit    = mapped && !idx_status;
    wire        write_block  = array_hit && (array_lock || chip_disabled ||
                                             (idx_factory && factory_lock));

    // Refused writes finish, flagged by pslverr
    wire        bad_access   = !mapped || (pwrite && write_block) || (pwrite && loading);
    wire        apb_write    = access && pwrite && !bad_access && array_hit;
    wire        status_write = access && pwrite && mapped && idx_status;

    wire        load_last    = loading && load_bit_valid && (shift_count == 7'(`CFG_BITS - 1));
    wire        load_commit  = load_last && !array_lock && !chip_disabled;
    wire [`CFG_BITS-1:0] next_shift = {shift_reg[`CFG_BITS-2:0], load_bit};

    logic [31:0] read_word;

    always_comb begin
        read_word = 32'h0000_0000;

        if (idx_byte) begin
            read_word[7:0] = cfg_mem[index];
        end else if (idx_seed) begin
            read_word[23:0] = {cfg_mem[5], cfg_mem[6], cfg_mem[7]};
        end else if (idx_key) begin
            read_word[23:0] = {cfg_mem[8], cfg_mem[9], cfg_mem[10]};
        end else if (idx_sync) begin
            read_word[7:0] = cfg_mem[11];
        end else if (idx_status) begin
            read_word[`ST_DISABLED] = chip_disabled;
            read_word[`ST_CUTOFF]   = tx_cutoff;
            read_word[`ST_LOW_CELL] = low_cell;
            read_word[`ST_LOADING]  = loading;
            read_word[`ST_REFUSED]  = refused;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states; read data is captured in the setup phase

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            if (setup) begin
                prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : read_word;
                pslverr <= bad_access;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array writes; the serial commit wins over an APB write in the same cycle

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `CFG_BYTES; i++) begin
                cfg_mem[i] <= `CFG_BYTE_RESET;
            end
        end else if (load_commit) begin
            for (int i = 0; i < `CFG_BYTES; i++) begin
                if (i != `CFG_BYTES - 1 || !factory_lock) begin
                    cfg_mem[i] <= next_shift[`CFG_BITS-1-8*i -: 8];
                end
            end
        end else if (apb_write) begin
            if (idx_byte || idx_sync || idx_factory) begin
                cfg_mem[index] <= merge_lane(cfg_mem[index], pwdata[7:0], pstrb[0]);
            end else if (idx_seed) begin
                cfg_mem[5] <= merge_lane(cfg_mem[5], pwdata[23:16], pstrb[2]);
                cfg_mem[6] <= merge_lane(cfg_mem[6], pwdata[15:8], pstrb[1]);
                cfg_mem[7] <= merge_lane(cfg_mem[7], pwdata[7:0], pstrb[0]);
            end else if (idx_key) begin
                cfg_mem[8]  <= merge_lane(cfg_mem[8], pwdata[23:16], pstrb[2]);
                cfg_mem[9]  <= merge_lane(cfg_mem[9], pwdata[15:8], pstrb[1]);
                cfg_mem[10] <= merge_lane(cfg_mem[10], pwdata[7:0], pstrb[0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial loader; locks are judged as they stood before the load

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg   <= '0;
            shift_count <= 7'd0;
            loading     <= 1'b0;
            load_done   <= 1'b0;
        end else begin
            load_done <= load_last;

            if (load_start) begin
                shift_count <= 7'd0;
                loading     <= 1'b1;
            end else if (loading && load_bit_valid) begin
                shift_reg   <= next_shift;
                shift_count <= shift_count + 7'd1;
                loading     <= !load_last;
            end
        end
    end

    // Set wins over a write-one clear
    wire next_refused = (load_last && !load_commit) || (access && pwrite && write_block) ||
                        (refused && !(status_write && pstrb[0] && pwdata[`ST_REFUSED]));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refused <= 1'b0;
        end else begin
            refused <= next_refused;
        end
    end

    // Both lock bits are the 7th and 8th bits loaded; reset stands for a fresh part
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_disabled <= 1'b0;
        end else if (supply_lost && array_lock && factory_lock) begin
            chip_disabled <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded settings

    rolling_code_config_pkg::cfg_s next_settings;
    always_comb begin
        next_settings                          = '0;

        next_settings.hold_to_resend_sync_en   = cfg_mem[0][`B0_RESYNC];
        next_settings.indicator_pin_select     = cfg_mem[0][`B0_INDICATOR];
        next_settings.cell_voltage_select      = cfg_mem[0][`B0_CELL];
        next_settings.long_press_cutoff_en     = cfg_mem[0][`B0_CUTOFF];

        next_settings.frame_gap_select         = cfg_mem[0][`B0_GAP_HI:`B0_GAP_LO];
        next_settings.frame_gap_ms             = gap_ms(cfg_mem[0][`B0_GAP_HI:`B0_GAP_LO]);
        next_settings.factory_byte_lock        = factory_lock;
        next_settings.array_write_lock         = array_lock;

        next_settings.preamble_field_on        = cfg_mem[1][`B1_PREAMBLE];
        next_settings.sync_field_coding_select = cfg_mem[1][`B1_SYNC_CODING];
        next_settings.sync_field_on            = cfg_mem[1][`B1_SYNC_ON];
        next_settings.key_identity_field_on    = cfg_mem[1][`B1_KEY_ON];
        next_settings.parity_field_on          = cfg_mem[1][`B1_PARITY_ON];
        next_settings.low_cell_detect_en       = cfg_mem[1][`B1_LOW_CELL];

        if (cfg_mem[1][`B1_KEY_ON]) begin
            next_settings.key_identity_bits = cfg_mem[1][`B1_KEY_LEN] ? `KEY_BITS_LONG
                                                                      : `KEY_BITS_SHORT;
        end
        next_settings.rolling_field_bits = cfg_mem[1][`B1_ROLL_LEN] ? `ROLL_BITS_LONG
                                                                    : `ROLL_BITS_SHORT;

        next_settings.bit_coding_format      = {cfg_mem[2][`B2_FAMILY],
                                                cfg_mem[2][`B2_FORMAT_HI:`B2_FORMAT_LO]};

        next_settings.transmit_polarity      = cfg_mem[2][`B2_POLARITY];
        next_settings.time_base_select       = cfg_mem[2][`B2_TIME_BASE];

        next_settings.frame_gap_divider      = {cfg_mem[2][1:0], cfg_mem[3][7:4]};
        next_settings.radio_clock_divider    = {cfg_mem[3][3:0], cfg_mem[4][7:6]};
        next_settings.infrared_clock_divider = cfg_mem[4][5:0];

        next_settings.rolling_seed           = {cfg_mem[5], cfg_mem[6], cfg_mem[7]};
        next_settings.key_identity_value     = {cfg_mem[8], cfg_mem[9], cfg_mem[10]};
        next_settings.sync_pattern_value     = cfg_mem[11];
    end

    // Registered for flop-driven outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settings <= '0;
        end else begin
            settings <= next_settings;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Key hold timing in milliseconds; the count saturates past the cutoff

    wire ms_tick  = (ms_count == 16'(MS_CYCLES - 1));
    wire hold_max = (hold_ms > `HOLD_W'(CUTOFF_MS));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_count <= 16'h0000;
            hold_ms  <= '0;
        end else if (!key_down || chip_disabled) begin
            ms_count <= 16'h0000;
            hold_ms  <= '0;
        end else begin
            ms_count <= ms_tick ? 16'h0000 : ms_count + 16'h0001;
            if (ms_tick && !hold_max) begin
                hold_ms <= hold_ms + `HOLD_W'(1);
            end
        end
    end

    // One pulse per press until key release
    wire past_resync = (hold_ms > `HOLD_W'(RESYNC_MS));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resync_request <= 1'b0;
            resync_sent    <= 1'b0;
            tx_cutoff      <= 1'b0;
        end else begin
            resync_request <= past_resync && !resync_sent && cfg_mem[0][`B0_RESYNC];
            resync_sent    <= key_down && (resync_sent || past_resync);
            tx_cutoff      <= key_down && cfg_mem[0][`B0_CUTOFF] && hold_max;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins; the analogue comparators sit outside and report per range

    wire cell_low = cfg_mem[0][`B0_CELL] ? cell_below_6v_range
                                         : cell_below_3v_range;

    wire tx_level = (tx_active && !tx_cutoff) ? (tx_data ^ cfg_mem[2][`B2_POLARITY])
                                              : cfg_mem[2][`B2_POLARITY];
    wire tick_sel = cfg_mem[2][`B2_TIME_BASE] ? radio_tick : infrared_tick;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cell                   <= 1'b0;
            tx_pin                     <= 1'b0;
            bit_tick                   <= 1'b0;
            radio_enable_indicator_pin <= 1'b0;
            clock_out_indicator_pin    <= 1'b0;
        end else begin
            low_cell                   <= cfg_mem[1][`B1_LOW_CELL] && cell_low;
            tx_pin                     <= chip_disabled ? cfg_mem[2][`B2_POLARITY] : tx_level;
            bit_tick                   <= tick_sel && !chip_disabled;
            radio_enable_indicator_pin <= led_on && !cfg_mem[0][`B0_INDICATOR];
            clock_out_indicator_pin    <= led_on && cfg_mem[0][`B0_INDICATOR];
        end
    end

endmodule : rolling_code_config_store

/* include/rolling_code_config_map.svh */
// Offsets, field positions, reset values and timing counts of the configuration store
`ifndef ROLLING_CODE_CONFIG_MAP_SVH
`define ROLLING_CODE_CONFIG_MAP_SVH
// Register indices; byte address is four times the index
`define IDX_OPTION_FLAGS      4'h0
`define IDX_FRAME_LAYOUT      4'h1
`define IDX_CODING_FORMAT     4'h2
`define IDX_PRESCALER_MIX     4'h3
`define IDX_INFRARED_PRESC    4'h4
`define IDX_ROLLING_SEED      4'h5
`define IDX_KEY_IDENTITY      4'h8
`define IDX_SYNC_PATTERN      4'hb
`define IDX_FACTORY_RESERVED  4'hc
`define IDX_STATUS            4'hd
`define CFG_BYTES             13
`define CFG_BITS              104
`define CFG_BYTE_RESET        8'h00
// Option flags byte
`define B0_RESYNC             7
`define B0_INDICATOR          6
`define B0_CELL               5
`define B0_CUTOFF             4
`define B0_GAP_HI             3
`define B0_GAP_LO             2
`define B0_FACTORY_LOCK       1
`define B0_ARRAY_LOCK         0
// Frame layout byte
`define B1_PREAMBLE           7
`define B1_SYNC_CODING        6
`define B1_SYNC_ON            5
`define B1_KEY_LEN            4
`define B1_KEY_ON             3
`define B1_ROLL_LEN           2
`define B1_PARITY_ON          1
`define B1_LOW_CELL           0
// Coding format byte
`define B2_FAMILY             7
`define B2_FORMAT_HI          6
`define B2_FORMAT_LO          4
`define B2_POLARITY           3
`define B2_TIME_BASE          2
// Status bits
`define ST_DISABLED           0
`define ST_CUTOFF             1
`define ST_LOW_CELL           2
`define ST_LOADING            3
`define ST_REFUSED            4
// Field lengths and gaps
`define KEY_BITS_SHORT        5'd20
`define KEY_BITS_LONG         5'd24
`define ROLL_BITS_SHORT       6'd24
`define ROLL_BITS_LONG        6'd36
`define GAP_MS_0              7'd0
`define GAP_MS_1              7'd20
`define GAP_MS_2              7'd50
`define GAP_MS_3              7'd100
// Timing
`define CLK_PERIOD_NS         40
`define MS_NS                 1000000
`define CLK_PER_MS            (`MS_NS / `CLK_PERIOD_NS)
`define RESYNC_HOLD_S         10
`define CUTOFF_HOLD_S         80
`define RESYNC_HOLD_MS        (`RESYNC_HOLD_S * 1000)
`define CUTOFF_HOLD_MS        (`CUTOFF_HOLD_S * 1000)
`define HOLD_W                17
`endif

/* include/rolling_code_config_pkg.sv */
// Types of the configuration store
package rolling_code_config_pkg;
    typedef struct packed {
        logic        hold_to_resend_sync_en;
        logic        indicator_pin_select;
        logic        cell_voltage_select;
        logic        long_press_cutoff_en;
        logic [1:0]  frame_gap_select;
        logic        factory_byte_lock;
        logic        array_write_lock;
        logic        preamble_field_on;
        logic        sync_field_coding_select;
        logic        sync_field_on;
        logic        key_identity_field_on;
        logic [4:0]  key_identity_bits;
        logic [5:0]  rolling_field_bits;
        logic        parity_field_on;
        logic        low_cell_detect_en;
        logic [3:0]  bit_coding_format;
        logic        transmit_polarity;
        logic        time_base_select;
        logic [5:0]  frame_gap_divider;
        logic [5:0]  radio_clock_divider;
        logic [5:0]  infrared_clock_divider;
        logic [23:0] rolling_seed;
        logic [23:0] key_identity_value;
        logic [7:0]  sync_pattern_value;
        logic [6:0]  frame_gap_ms;
    } cfg_s;
endpackage : rolling_code_config_pkg

/* sim/rolling_code_config_monitor.sv */
// Output checks of the configuration store
`timescale 1ns/100ps
module rolling_code_config_monitor (
    input wire logic clk, rst, supply_lost, key_down, led_on, tx_active, radio_tick, infrared_tick,
    input wire logic cell_below_3v_range, cell_below_6v_range, resync_request, tx_cutoff, low_cell,
    input wire logic tx_pin, tx_data, bit_tick, radio_enable_indicator_pin, clock_out_indicator_pin, chip_disabled,
    input wire rolling_code_config_pkg::cfg_s settings
);
    rolling_code_config_pkg::cfg_s prev;
    logic                          steady;
    // Pins and settings change on the same edge; the pin checks judge only steady cycles
    assign steady = prev == settings && !chip_disabled;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) prev <= '0;
        else prev <= settings;
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    a_led_route: assert property (steady |->
        radio_enable_indicator_pin == ($past(led_on) && !settings.indicator_pin_select)) else $error("led pin");
    a_led_alt: assert property (steady |->
        clock_out_indicator_pin == ($past(led_on) && settings.indicator_pin_select)) else $error("led alt pin");
    a_cell_pick: assert property (steady |-> low_cell == (settings.low_cell_detect_en &&
        (settings.cell_voltage_select ? $past(cell_below_6v_range) : $past(cell_below_3v_range)))) else $error("cell");
    a_tick_src: assert property (steady |->
        bit_tick == (settings.time_base_select ? $past(radio_tick) : $past(infrared_tick))) else $error("tick");
    a_tx_idle: assert property (steady && !($past(tx_active) && !$past(tx_cutoff)) |->
        tx_pin == settings.transmit_polarity) else $error("tx idle");
    a_tx_data: assert property (steady && $past(tx_active) && !$past(tx_cutoff) |->
        tx_pin == ($past(tx_data) ^ settings.transmit_polarity)) else $error("tx data");
    a_resync_once: assert property (resync_request |-> settings.hold_to_resend_sync_en ##1 !resync_request [*8])
        else $error("resync");
    a_cut_cause: assert property (tx_cutoff |-> settings.long_press_cutoff_en && $past(key_down))
        else $error("cutoff");
    a_cut_release: assert property (!key_down |=> !tx_cutoff) else $error("cutoff held");
    a_dis_set: assert property (supply_lost && settings.factory_byte_lock && settings.array_write_lock
        |=> chip_disabled) else $error("disable");
    a_dis_keep: assert property (chip_disabled |=> chip_disabled) else $error("disable lost");
    c_resync: cover property (resync_request);
    c_cutoff: cover property (tx_cutoff);
    c_dis: cover property (chip_disabled);
endmodule : rolling_code_config_monitor
bind rolling_code_config_store rolling_code_config_monitor i_mon (.*);

/* sim/serial_programmer.sv */
// Programmer model shifting a configuration image into the store
`timescale 1ns/100ps
module serial_programmer (
    input  wire logic         clk,
    input  wire logic         go,
    input  wire logic         slow,
    input  wire logic [103:0] image,
    output logic              load_start = 1'b0,
    output logic              load_bit = 1'b0,
    output logic              load_bit_valid = 1'b0
);
    logic [103:0] sr = '0;
    logic [6:0]   left = 7'h0;
    logic         shift;
    assign shift = !go && left != 7'h0 && !(slow && load_bit_valid);
    always @(posedge clk) begin
        load_start <= go;
        load_bit_valid <= shift;
        // Line toggles between bits so a stale level never passes for data
        load_bit <= shift ? sr[103] : ~load_bit;
        if (go) {sr, left} <= {image, 7'h68};
        else if (shift) {sr, left} <= {sr[102:0], 1'b0, left - 7'h1};
    end
endmodule : serial_programmer

/* sim/testbench.sv */
// Self-checking bench of the configuration store
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("BAD %0t %h %h", $time, g, e); end end
module testbench;
    int seed = 32'hfa20_4d17, errors = 0, num_checks = 0, cycles = 0, n;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, supply_lost = 0, key_down = 0, go = 0, slow = 0;
    logic led_on = 0, tx_active = 0, tx_data = 0, radio_tick = 0, infrared_tick = 0, er;
    logic cell_below_3v_range = 0, cell_below_6v_range = 0, load_start, load_bit, load_bit_valid, load_done;
    logic pready, pslverr, resync_request, tx_cutoff, low_cell, tx_pin, bit_tick, chip_disabled;
    logic radio_enable_indicator_pin, clock_out_indicator_pin;
    logic [7:0] paddr = 0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [103:0] image = 0;
    logic [7:0] adr [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h2c, 8'h30};
    rolling_code_config_pkg::cfg_s settings;
    rolling_code_config_store #(.MS_CYCLES(4), .RESYNC_MS(3), .CUTOFF_MS(6)) i_dut (.*);
    serial_programmer i_prog (.*);
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (!rst) {led_on, tx_active, tx_data, radio_tick, infrared_tick,
            cell_below_3v_range, cell_below_6v_range} <= 7'($random(seed));
        if (cycles == 6000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask : apb
    task automatic load(input logic s);
        {slow, go} <= {s, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 400 && load_done !== 1'b1; i++) @(posedge clk);
        `CHK(load_done, 1'b1)
        @(posedge clk);
    endtask : load
    function automatic logic [31:0] word(input int k);
        if (k == 5) return {8'h00, image[63:40]};
        if (k == 6) return {8'h00, image[39:16]};
        return {24'h00_0000, image[103 - 8 * (k < 5 ? k : k + 4) -: 8]};
    endfunction : word
    function automatic rolling_code_config_pkg::cfg_s exp_cfg(input logic [103:0] m);
        logic [6:0] ms;
        ms = m[99:98] == 2'h0 ? 7'h00 : m[99:98] == 2'h1 ? 7'h14 : m[99:98] == 2'h2 ? 7'h32 : 7'h64;
        return {m[103:93], m[91], m[91] ? (m[92] ? 5'h18 : 5'h14) : 5'h00, m[90] ? 6'h24 : 6'h18, m[89:8], ms};
    endfunction : exp_cfg
    task automatic rand_image;
        image = {$random(seed), $random(seed), $random(seed), 8'($random(seed))};
        image[97:96] = 2'b00; // Locks stay clear until the lock test
    endtask : rand_image
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int r = 0; r < 4; r++) begin
            if (r > 0) rand_image();
            for (int k = 0; k < 9 && r > 0; k++) apb(1'b1, adr[k], word(k));
            for (int k = 0; k < 9; k++) begin
                apb(1'b0, adr[k], 32'h0);
                `CHK(rd, (k == 8 ? 32'h0 : word(k)))
            end
            `CHK(settings, exp_cfg(image))
        end
        $display("end register access");
        for (int r = 0; r < 2; r++) begin
            rand_image();
            load(r[0]);
            `CHK(settings, exp_cfg(image))
        end
        $display("end serial load");
        for (int r = 0; r < 2; r++) begin
            apb(1'b1, 8'h00, r ? 32'h0000_0000 : 32'h0000_0090);
            n = 0;
            key_down <= 1'b1;
            for (int i = 0; i < 64; i++) begin
                @(posedge clk);
                n += resync_request;
                if (i == 20) `CHK(tx_cutoff, 1'b0)
            end
            `CHK(n, (r ? 0 : 1))
            `CHK(tx_cutoff, (r ? 1'b0 : 1'b1))
            key_down <= 1'b0;
            repeat (2) @(posedge clk);
            `CHK(tx_cutoff, 1'b0)
        end
        $display("end key hold");
        apb(1'b1, 8'h18, 32'h0000_0001);
        `CHK(er, 1'b1)
        apb(1'b1, 8'h00, 32'h0000_0002);
        apb(1'b1, 8'h30, 32'h0000_005a);
        `CHK(er, 1'b1)
        apb(1'b1, 8'h2c, 32'h0000_0033);
        `CHK(er, 1'b0)
        supply_lost <= 1'b1;
        @(posedge clk);
        supply_lost <= 1'b0;
        apb(1'b1, 8'h00, 32'h0000_0003);
        `CHK(chip_disabled, 1'b0)
        apb(1'b1, 8'h2c, 32'h0000_0044);
        `CHK(er, 1'b1)
        apb(1'b0, 8'h34, 32'h0);
        `CHK({rd[4], rd[0]}, 2'b10)
        rand_image();
        load(1'b0);
        apb(1'b0, 8'h2c, 32'h0);
        `CHK(rd, 32'h0000_0033)
        supply_lost <= 1'b1;
        @(posedge clk);
        supply_lost <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(chip_disabled, 1'b1)
        $display("end locks");
        report_and_stop();
    end
endmodule : testbench
